// ---- src/tbec_pkg.sv ----
// shared constants and types for the trace buffer management-event block
package tbec_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_LIMIT = 5'h00;
    localparam logic [4:0] OFF_BASE = 5'h04;
    localparam logic [4:0] OFF_PTR = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0C;

    // limit pointer register fields
    localparam int LIM_EN_BIT = 0;
    localparam int LIM_MODE_LSB = 1;
    localparam int LIM_TRG_BIT = 3;
    // pointers are kept in 16-byte granules
    localparam int ADDR_LSB = 4;
    localparam int PTR_W = 28;

    // status register fields
    localparam int ST_IRQ = 0;
    localparam int ST_STOP = 1;
    localparam int ST_WRAP = 2;
    localparam int ST_BSC_LSB = 3;
    localparam int ST_EC_LSB = 8;
    localparam int ST_MSS_LSB = 16;

    // values after reset
    localparam logic RST_WAIT = 1'b1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_FILL = 2'h0,
        MODE_WRAP = 2'h1,
        MODE_RSVD = 2'h2,
        MODE_CIRC = 2'h3
    } buf_mode_t;

    // event class and buffer status codes
    localparam logic [5:0] EC_OTHER = 6'h00;
    localparam logic [5:0] EC_FAULT = 6'h01;
    localparam logic [5:0] EC_ABORT = 6'h02;
    localparam logic [4:0] BSC_FILLED = 5'h01;
    localparam logic [4:0] BSC_TRIGGER = 5'h02;

    // syndrome bits
    localparam logic [15:0] MSS_ALIGN = 16'h0001;
    localparam logic [15:0] MSS_XLAT = 16'h0002;
    localparam logic [15:0] MSS_SABT = 16'h0004;
    localparam logic [15:0] MSS_AABT = 16'h0008;
    localparam logic [15:0] MSS_PROG = 16'h0010;
    localparam logic [15:0] MSS_IMPDEF = 16'h0020;
endpackage : tbec_pkg

// ---- src/ptr_step.sv ----
// write pointer increment with wrap to base at the limit
`timescale 1ns/1ps
module ptr_step
#(
    parameter int AW = 28
)
(
    input wire logic [AW-1:0] i_ptr, // current pointer
    input wire logic [AW-1:0] i_base, // base pointer
    input wire logic [AW-1:0] i_limit, // limit pointer
    output logic [AW-1:0] o_next, // pointer after one beat
    output logic o_wrap // next beat wraps to base
);
    logic [AW-1:0] inc;

    if (AW < 2)
    begin : g_bad_aw
        $error("ptr_step: AW must be at least 2");
    end

    always_comb
    begin
        inc = i_ptr + {{(AW-1){1'b0}}, 1'b1};
        o_wrap = (inc == i_limit);
        o_next = o_wrap ? i_base : inc;
    end
endmodule : ptr_step

// ---- src/evt_prio.sv ----
// one-hot selection among coinciding synchronous events
`timescale 1ns/1ps
module evt_prio
(
    input wire logic i_fault, // alignment or translation fault
    input wire logic i_sabt, // synchronous external abort
    input wire logic i_full, // buffer full
    input wire logic i_wrap, // buffer wrap
    output logic [3:0] o_sel // {wrap, full, sabt, fault}
);
    always_comb
    begin
        o_sel = 4'h0;
        if (i_fault)
        begin
            o_sel = 4'h1;
        end
        else if (i_sabt)
        begin
            o_sel = 4'h2;
        end
        else if (i_full)
        begin
            o_sel = 4'h4;
        end
        else if (i_wrap)
        begin
            o_sel = 4'h8;
        end
    end
endmodule : evt_prio

// ---- src/tbec_mgmt.sv ----
// trace buffer management events, pointer wrap and interrupt request
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module tbec_mgmt
(
    input wire logic i_clk, // core clock, 40 MHz
    input wire logic i_sys_rst, // async reset, active high
    input wire logic [4:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read request
    input wire logic i_avs_write, // write request
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // stall
    input wire logic i_trc_valid, // trace beat offered
    output logic o_trc_ready, // beat accepted when valid
    output logic [31:0] o_wr_addr, // address of the next beat
    input wire logic i_wr_align_flt, // accepted beat: alignment fault
    input wire logic i_wr_xlat_flt, // accepted beat: translation fault
    input wire logic i_wr_sync_abt, // accepted beat: sync abort
    input wire logic i_async_abt, // asynchronous external abort
    input wire logic i_trig_evt, // trigger event from counter
    input wire logic i_flush_done, // trace source flush finished
    input wire logic i_prog_err, // disallowed programming sequence
    input wire logic i_impdef_evt, // implementation condition
    output logic o_flush_req, // one-cycle flush request
    output logic o_wrap_pulse, // one-cycle pointer wrap event
    output logic o_mgmt_irq // private core interrupt level
);
    typedef struct packed {
        logic wait_b;
        logic [31:0] rdata;
        logic en;
        tbec_pkg::buf_mode_t mode;
        logic trg_en;
        logic [27:0] limit;
        logic [27:0] base;
        logic [27:0] ptr;
        logic irq;
        logic stopped;
        logic wrap;
        logic [4:0] bsc;
        logic [5:0] ec;
        logic [15:0] mss;
        logic flush_pend;
        logic flush;
        logic wrap_pulse;
        logic ready;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [27:0] step_ptr;
    logic step_wrap;
    logic [3:0] sel;
    logic req;
    logic acc;
    logic flt;
    logic sabt;
    logic adv;
    logic full_ev;
    logic wrap_ev;
    logic sw_ptr_wr;
    logic sw_st_wr;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old_w,
        input logic [31:0] new_w, input logic [3:0] be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    ptr_step #(
        .AW(tbec_pkg::PTR_W)
    ) u_step (
        .i_ptr(st_reg.ptr),
        .i_base(st_reg.base),
        .i_limit(st_reg.limit),
        .o_next(step_ptr),
        .o_wrap(step_wrap)
    );

    always_comb
    begin
        req = i_avs_read | i_avs_write;
        acc = i_trc_valid & st_reg.ready;
        flt = acc & (i_wr_align_flt | i_wr_xlat_flt);
        sabt = acc & i_wr_sync_abt;
        adv = acc & ~flt & ~sabt;
        full_ev = adv & step_wrap & (st_reg.mode != tbec_pkg::MODE_WRAP)
            & (st_reg.mode != tbec_pkg::MODE_CIRC);
        wrap_ev = adv & step_wrap & (st_reg.mode == tbec_pkg::MODE_WRAP);
        sw_ptr_wr = i_avs_write & ~st_reg.wait_b & (i_avs_address == tbec_pkg::OFF_PTR);
        sw_st_wr = i_avs_write & ~st_reg.wait_b & (i_avs_address == tbec_pkg::OFF_STATUS);
    end

    evt_prio u_prio (
        .i_fault(flt),
        .i_sabt(sabt),
        .i_full(full_ev),
        .i_wrap(wrap_ev),
        .o_sel(sel)
    );

    always_comb
    begin
        logic [31:0] w;
        w = tbec_pkg::RST_WORD;
        st_next = st_reg;
        st_next.flush = 1'b0;
        st_next.wrap_pulse = 1'b0;
        // answer every request one cycle after it is first seen
        st_next.wait_b = ~(req & st_reg.wait_b);
        if (req & st_reg.wait_b)
        begin
            unique case (i_avs_address)
                tbec_pkg::OFF_LIMIT: st_next.rdata = {st_reg.limit, st_reg.trg_en,
                    st_reg.mode, st_reg.en};
                tbec_pkg::OFF_BASE: st_next.rdata = {st_reg.base, 4'h0};
                tbec_pkg::OFF_PTR: st_next.rdata = {st_reg.ptr, 4'h0};
                tbec_pkg::OFF_STATUS: st_next.rdata = {st_reg.mss, 2'h0, st_reg.ec,
                    st_reg.bsc, st_reg.wrap, st_reg.stopped, st_reg.irq};
                default: st_next.rdata = tbec_pkg::RST_WORD;
            endcase
        end
        if (i_avs_write & ~st_reg.wait_b)
        begin
            unique case (i_avs_address)
                tbec_pkg::OFF_LIMIT:
                begin
                    w = merge({st_reg.limit, st_reg.trg_en, st_reg.mode, st_reg.en},
                        i_avs_writedata, i_avs_byteenable);
                    st_next.en = w[tbec_pkg::LIM_EN_BIT];
                    st_next.mode = tbec_pkg::buf_mode_t'(w[tbec_pkg::LIM_MODE_LSB +: 2]);
                    st_next.trg_en = w[tbec_pkg::LIM_TRG_BIT];
                    st_next.limit = w[31:tbec_pkg::ADDR_LSB];
                end
                tbec_pkg::OFF_BASE:
                begin
                    w = merge({st_reg.base, 4'h0}, i_avs_writedata, i_avs_byteenable);
                    st_next.base = w[31:tbec_pkg::ADDR_LSB];
                end
                tbec_pkg::OFF_PTR:
                begin
                    w = merge({st_reg.ptr, 4'h0}, i_avs_writedata, i_avs_byteenable);
                    st_next.ptr = w[31:tbec_pkg::ADDR_LSB];
                end
                tbec_pkg::OFF_STATUS:
                begin
                    w = merge({st_reg.mss, 2'h0, st_reg.ec, st_reg.bsc, st_reg.wrap,
                        st_reg.stopped, st_reg.irq}, i_avs_writedata, i_avs_byteenable);
                    st_next.irq = w[tbec_pkg::ST_IRQ];
                    st_next.stopped = w[tbec_pkg::ST_STOP];
                    st_next.wrap = w[tbec_pkg::ST_WRAP];
                    st_next.bsc = w[tbec_pkg::ST_BSC_LSB +: 5];
                    st_next.ec = w[tbec_pkg::ST_EC_LSB +: 6];
                    st_next.mss = w[tbec_pkg::ST_MSS_LSB +: 16];
                end
                default:
                begin
                    w = tbec_pkg::RST_WORD;
                end
            endcase
        end
        // hardware events come after the software write so a set wins
        if (adv)
        begin
            st_next.ptr = step_ptr;
            if (step_wrap)
            begin
                st_next.wrap = 1'b1;
                st_next.wrap_pulse = 1'b1;
            end
        end
        if (sel[0])
        begin
            // pointer left as is: it names the faulting beat
            st_next.irq = 1'b1;
            st_next.stopped = 1'b1;
            st_next.ec = tbec_pkg::EC_FAULT;
            st_next.mss = i_wr_align_flt ? tbec_pkg::MSS_ALIGN : tbec_pkg::MSS_XLAT;
        end
        if (sel[1])
        begin
            st_next.irq = 1'b1;
            st_next.stopped = 1'b1;
            st_next.ec = tbec_pkg::EC_ABORT;
            st_next.mss = tbec_pkg::MSS_SABT;
        end
        if (sel[2])
        begin
            st_next.irq = 1'b1;
            if (~st_reg.stopped)
            begin
                st_next.stopped = 1'b1;
                st_next.ec = tbec_pkg::EC_OTHER;
                st_next.bsc = tbec_pkg::BSC_FILLED;
            end
        end
        if (sel[3])
        begin
            st_next.irq = 1'b1;
        end
        // asynchronous sources sit outside the ranking above
        if (i_async_abt)
        begin
            st_next.irq = 1'b1;
            st_next.stopped = 1'b1;
            st_next.mss = st_next.mss | tbec_pkg::MSS_AABT;
            if (sel == 4'h0)
            begin
                st_next.ec = tbec_pkg::EC_ABORT;
            end
        end
        if (i_trig_evt & st_reg.trg_en & st_reg.en)
        begin
            st_next.irq = 1'b1;
            st_next.flush = 1'b1;
            st_next.flush_pend = 1'b1;
            if (sel == 4'h0)
            begin
                st_next.ec = tbec_pkg::EC_OTHER;
                st_next.bsc = tbec_pkg::BSC_TRIGGER;
            end
        end
        // flush writes keep flowing until the source reports completion
        if (i_flush_done & st_reg.flush_pend)
        begin
            st_next.flush_pend = 1'b0;
            st_next.stopped = 1'b1;
        end
        if (i_prog_err | i_impdef_evt)
        begin
            st_next.irq = 1'b1;
            st_next.mss = st_next.mss | (i_prog_err ? tbec_pkg::MSS_PROG : 16'h0000)
                | (i_impdef_evt ? tbec_pkg::MSS_IMPDEF : 16'h0000);
        end
        st_next.ready = st_next.en & ~st_next.stopped;
    end

    // whole state in one register so every field of an event lands together
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_reg <= '0;
            st_reg.wait_b <= tbec_pkg::RST_WAIT;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_avs_readdata = st_reg.rdata;
    assign o_avs_waitrequest = st_reg.wait_b;
    assign o_trc_ready = st_reg.ready;
    assign o_wr_addr = {st_reg.ptr, 4'h0};
    assign o_flush_req = st_reg.flush;
    assign o_wrap_pulse = st_reg.wrap_pulse;
    // plain level, no handshake: the core samples it whenever it likes
    assign o_mgmt_irq = st_reg.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic quiet;
    assign quiet = ~i_async_abt & ~i_flush_done & ~sw_st_wr;

    sequence frozen_s;
        st_reg.stopped && st_reg.irq && !o_trc_ready;
    endsequence

    sequence answer_s;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    circ_wrap_a: assert property (
        adv && step_wrap && st_reg.mode == tbec_pkg::MODE_CIRC && quiet
        |=> st_reg.ptr == $past(st_reg.base) && st_reg.stopped == $past(st_reg.stopped)
            && o_wrap_pulse)
        else $error("circular wrap did not reload base quietly");

    wrap_mode_irq_a: assert property (
        adv && step_wrap && st_reg.mode == tbec_pkg::MODE_WRAP && quiet
        |=> o_mgmt_irq && st_reg.wrap && !st_reg.stopped && st_reg.ptr == $past(st_reg.base))
        else $error("wrap mode wrap did not request interrupt");

    fill_stop_a: assert property (
        adv && step_wrap && st_reg.mode == tbec_pkg::MODE_FILL && !st_reg.stopped
            && !i_async_abt && !(i_trig_evt && st_reg.trg_en)
        |=> frozen_s ##0 st_reg.ec == tbec_pkg::EC_OTHER
            && st_reg.bsc == tbec_pkg::BSC_FILLED && st_reg.wrap)
        else $error("fill mode wrap did not stop with filled status");

    fault_freeze_a: assert property (
        (flt || sabt) && !sw_ptr_wr
        |=> frozen_s ##0 st_reg.ptr == $past(st_reg.ptr))
        else $error("fault did not freeze pointer and stop");

    stop_no_adv_a: assert property (
        st_reg.stopped && !sw_ptr_wr |=> $stable(st_reg.ptr) && !o_wrap_pulse)
        else $error("pointer moved while stopped");

    irq_hold_a: assert property (
        o_mgmt_irq && !sw_st_wr |=> o_mgmt_irq)
        else $error("interrupt dropped without software clear");

    sw_irq_set_a: assert property (
        sw_st_wr && i_avs_byteenable[0] && i_avs_writedata[tbec_pkg::ST_IRQ]
        |=> o_mgmt_irq)
        else $error("software set of request bit did not raise interrupt");

    fault_rank_a: assert property (
        flt && sabt |=> st_reg.ec == tbec_pkg::EC_FAULT && st_reg.mss != tbec_pkg::MSS_SABT)
        else $error("fault not ranked above synchronous abort");

    trig_flush_a: assert property (
        i_trig_evt && st_reg.trg_en && st_reg.en |=> o_flush_req && o_mgmt_irq ##1 !o_flush_req)
        else $error("trigger event did not request one flush");

    bus_answer_a: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> answer_s)
        else $error("bus request not answered in one cycle");
endmodule : tbec_mgmt

// ---- dv/trace_src_model.sv ----
// trace source partner: offers beats, flags write faults, answers flush requests
`timescale 1ns/1ps
module trace_src_model
(
    input wire logic i_clk, // core clock
    input wire logic i_sys_rst, // async reset, active high
    input wire logic i_offer, // bench asks for beats
    input wire logic [1:0] i_flt_kind, // 1 align with sync abort, 2 xlat, 3 sync abort
    input wire logic i_flush_req, // flush request from the block
    output logic o_trc_valid, // beat offered
    output logic o_align, // alignment fault on the offered beat
    output logic o_xlat, // translation fault on the offered beat
    output logic o_sabt, // sync abort on the offered beat
    output logic o_flush_done // flush finished pulse
);
    logic [1:0] cnt_reg;
    // qualifiers only mean something with a beat, so they follow valid
    assign o_trc_valid = i_offer;
    assign o_align = i_offer && (i_flt_kind == 2'h1);
    assign o_xlat = i_offer && (i_flt_kind == 2'h2);
    // kind 1 raises two synchronous events at once so the ranking is exercised
    assign o_sabt = i_offer && ((i_flt_kind == 2'h3) || (i_flt_kind == 2'h1));
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cnt_reg <= 2'h0;
            o_flush_done <= 1'b0;
        end
        else
        begin
            // slow flush: done a few cycles after the request
            if (i_flush_req) cnt_reg <= 2'h3;
            else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
            o_flush_done <= (cnt_reg == 2'h1);
        end
    end
endmodule : trace_src_model

// ---- dv/testbench.sv ----
// self-checking bench for the management-event block
`timescale 1ns/1ps
module testbench;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [4:0] i_avs_address = 5'h00;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, o_wr_addr, q, base;
    logic o_avs_waitrequest, o_trc_ready, o_flush_req, o_wrap_pulse, o_mgmt_irq;
    logic offer = 1'b0, valid, al, xl, sa, fdone, flushed;
    logic i_trig_evt = 1'b0, i_async_abt = 1'b0, i_prog_err = 1'b0, i_impdef_evt = 1'b0;
    logic [1:0] flt = 2'h0, md;
    int seed = 32'hE79C, mismatches = 0, compares = 0, wraps = 0, cyc = 0, k, w0;
    tbec_mgmt dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_trc_valid(valid), .o_trc_ready(o_trc_ready),
        .o_wr_addr(o_wr_addr), .i_wr_align_flt(al), .i_wr_xlat_flt(xl), .i_wr_sync_abt(sa),
        .i_async_abt(i_async_abt), .i_trig_evt(i_trig_evt), .i_flush_done(fdone),
        .i_prog_err(i_prog_err), .i_impdef_evt(i_impdef_evt), .o_flush_req(o_flush_req),
        .o_wrap_pulse(o_wrap_pulse), .o_mgmt_irq(o_mgmt_irq));
    trace_src_model src (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_offer(offer),
        .i_flt_kind(flt), .i_flush_req(o_flush_req), .o_trc_valid(valid), .o_align(al),
        .o_xlat(xl), .o_sabt(sa), .o_flush_done(fdone));
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        if (o_wrap_pulse === 1'b1) wraps <= wraps + 1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= d;
        // no local limit: a missing answer ends in the cycle timeout
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_avs_waitrequest !== 1'b0);
        chk("bus answer", 32'(n), 32'h2);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus
    // the last of n beats carries fault kind fk
    task beats(input int n, input logic [1:0] fk);
        int c, t;
        c = 0;
        t = 0;
        offer <= 1'b1;
        flt <= (n == 1) ? fk : 2'h0;
        while (c < n && t < 50)
        begin
            @(posedge i_clk);
            t++;
            if (offer === 1'b1 && o_trc_ready === 1'b1) c++;
            flt <= (c == n - 1) ? fk : 2'h0;
        end
        offer <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask : beats
    task pulse(input int s);
        @(posedge i_clk);
        if (s == 0) i_async_abt <= 1'b1;
        if (s == 1) i_prog_err <= 1'b1;
        if (s == 2) i_impdef_evt <= 1'b1;
        if (s == 3) i_trig_evt <= 1'b1;
        @(posedge i_clk);
        {i_async_abt, i_prog_err, i_impdef_evt, i_trig_evt} <= 4'h0;
        flushed = 1'b0;
        repeat (3)
        begin
            @(posedge i_clk);
            if (o_flush_req === 1'b1) flushed = 1'b1;
        end
    endtask : pulse
    task setup(input logic [1:0] m, input logic trg);
        base = $random(seed) & 32'h00FF_FFF0;
        bus(1'b1, tbec_pkg::OFF_STATUS, 32'h0);
        bus(1'b1, tbec_pkg::OFF_BASE, base);
        bus(1'b1, tbec_pkg::OFF_PTR, base);
        bus(1'b1, tbec_pkg::OFF_LIMIT, (base + 32'h40) | {trg, m, 1'b1});
    endtask : setup
    task final_report;
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 5; a++)
        begin
            bus(1'b0, 5'(a * 4), 32'h0);
            chk("reset value", q, tbec_pkg::RST_WORD);
        end
        for (int i = 0; i < 4; i++)
        begin
            md = (i == 0) ? tbec_pkg::MODE_CIRC : (i == 1) ? tbec_pkg::MODE_WRAP
                : (i == 2) ? tbec_pkg::MODE_FILL : tbec_pkg::MODE_RSVD;
            setup(md, 1'b0);
            w0 = wraps;
            beats(4, 2'h0);
            chk("wrap pulses", 32'(wraps - w0), 32'h1);
            chk("addr after wrap", o_wr_addr, base);
            chk("irq after wrap", {31'h0, o_mgmt_irq}, {31'h0, i != 0});
            chk("ready after wrap", {31'h0, o_trc_ready}, {31'h0, i < 2});
            bus(1'b0, tbec_pkg::OFF_STATUS, 32'h0);
            chk("status after wrap", q,
                {24'h0, (i >= 2) ? tbec_pkg::BSC_FILLED : 5'h00, 1'b1, i >= 2, i != 0});
        end
        beats(2, 2'h0);
        chk("stopped pointer", o_wr_addr, base);
        bus(1'b0, tbec_pkg::OFF_PTR, 32'h0);
        chk("stopped ptr reg", q, base);
        bus(1'b1, tbec_pkg::OFF_STATUS, 32'h0);
        repeat (2) @(posedge i_clk);
        chk("irq cleared", {31'h0, o_mgmt_irq}, 32'h0);
        bus(1'b1, tbec_pkg::OFF_STATUS, 32'h1);
        repeat (2) @(posedge i_clk);
        chk("irq by software", {31'h0, o_mgmt_irq}, 32'h1);
        for (int i = 0; i < 7; i++)
        begin
            md = (i == 6) ? tbec_pkg::MODE_FILL : tbec_pkg::MODE_CIRC;
            k = (i == 6) ? 3 : ($random(seed) & 32'h3) % 3;
            setup(md, 1'b0);
            beats(k + 1, 2'((i % 3) + 1));
            bus(1'b0, tbec_pkg::OFF_PTR, 32'h0);
            chk("frozen pointer", q, base + 32'(k * 16));
            bus(1'b0, tbec_pkg::OFF_STATUS, 32'h0);
            chk("fault status", q & 32'hFFFF_FF03, {(i % 3 == 0) ? tbec_pkg::MSS_ALIGN :
                (i % 3 == 1) ? tbec_pkg::MSS_XLAT : tbec_pkg::MSS_SABT, 2'b00,
                (i % 3 == 2) ? tbec_pkg::EC_ABORT : tbec_pkg::EC_FAULT, 8'h03});
            chk("ready after fault", {31'h0, o_trc_ready}, 32'h0);
        end
        setup(tbec_pkg::MODE_CIRC, 1'b0);
        pulse(3);
        chk("trigger disabled", {30'h0, o_mgmt_irq, flushed}, 32'h0);
        for (int s = 0; s < 3; s++)
        begin
            bus(1'b1, tbec_pkg::OFF_STATUS, 32'h0);
            pulse(s);
            bus(1'b0, tbec_pkg::OFF_STATUS, 32'h0);
            chk("async event", q & 32'hFFFF_0001, {(s == 0) ? tbec_pkg::MSS_AABT : (s == 1) ?
                tbec_pkg::MSS_PROG : tbec_pkg::MSS_IMPDEF, 16'h0001});
        end
        setup(tbec_pkg::MODE_CIRC, 1'b1);
        pulse(3);
        chk("trigger flush", {31'h0, flushed}, 32'h1);
        repeat (4) @(posedge i_clk);
        chk("trigger irq", {31'h0, o_mgmt_irq}, 32'h1);
        bus(1'b0, tbec_pkg::OFF_STATUS, 32'h0);
        chk("trigger status", q & 32'h0000_3FFB, {24'h0, tbec_pkg::BSC_TRIGGER, 3'b011});
        final_report();
    end
endmodule : testbench
